/* design/cifg_gate.sv */
// Interrupt flag gating unit with an AXI4-Lite register slave.
module cifg_gate #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Request and trap events from logic on the same clock.
  input wire cifg_pkg::cifg_irq_t irq_in,
  input wire cifg_pkg::cifg_trap_t trap_in,
  // Outputs toward the sequencer.
  output logic irq_accept,
  output logic [2:0] accept_level,
  output logic gate_flag,
  output logic stack_sel,
  output logic [2:0] cpu_priority_level,
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cifg_pkg::*;

  // Map a byte address onto a register; only whole aligned words match.
  function automatic cifg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    cifg_sel_t s;
    s = CIFG_SEL_NONE;
    if (a == ADDR_W'(FLAGS_OFS)) begin
      s = CIFG_SEL_FLAGS;
    end else if (a == ADDR_W'(STATUS_OFS)) begin
      s = CIFG_SEL_STATUS;
    end
    return s;
  endfunction

  // Flag state held by the core.
  logic gate_reg;
  logic stack_reg;
  logic [2:0] level_reg;
  // Acceptance pulse and what was accepted.
  logic accept_reg;
  logic [2:0] acc_level_reg;
  logic acc_maskable_reg;

  // Write channel holding registers.
  logic awready_reg;
  logic wready_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  // Read channel registers.
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Priority compare and gate, kept as named wires for visibility.
  wire prio_ok = irq_in.level > level_reg;
  wire mask_ok = gate_reg & prio_ok;
  // A request is not taken on two cycles running; the pulse gap lets flags settle.
  wire eligible = irq_in.valid & ~accept_reg &
                  (irq_in.maskable ? mask_ok : 1'b1);
  wire accept_fire = ce & eligible;
  wire trap_fire = ce & trap_in.exec;
  wire trap_low = trap_fire & (trap_in.num <= TRAP_CLEAR_MAX);

  // Bus handshakes.
  wire aw_take = ce & s_axi_awvalid & awready_reg;
  wire w_take = ce & s_axi_wvalid & wready_reg;
  wire wr_do = ce & aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire b_done = ce & bvalid_reg & s_axi_bready;
  wire ar_take = ce & s_axi_arvalid & arready_reg;
  wire r_done = ce & rvalid_reg & s_axi_rready;
  wire cifg_sel_t wr_sel = reg_sel(awaddr_reg);
  wire cifg_sel_t rd_sel = reg_sel(s_axi_araddr);
  // Only byte lane 0 carries flag bits, so only it enables the write.
  wire flag_wr = wr_do & (wr_sel == CIFG_SEL_FLAGS) & wstrb_reg[0];

  // Next flag values. An acknowledge in the same cycle as a software
  // write wins, so an accepted interrupt is never left unmasked.
  wire gate_next = (accept_fire | trap_fire) ? 1'b0 :
                   flag_wr ? wdata_reg[GATE_BIT] : gate_reg;
  wire stack_next = (accept_fire | trap_low) ? 1'b0 :
                    flag_wr ? wdata_reg[STACK_BIT] : stack_reg;
  wire [2:0] level_next = flag_wr ?
                          wdata_reg[LEVEL_LSB +: LEVEL_W] : level_reg;

  // Read data; the reserved bit is returned as zero.
  wire [31:0] flags_word = {25'h0, level_reg, 1'b0, 1'b0,
                            stack_reg, gate_reg};
  wire [31:0] status_word = {23'h0, eligible, 4'h0, acc_maskable_reg,
                             acc_level_reg};
  wire [31:0] rd_word = (rd_sel == CIFG_SEL_FLAGS) ? flags_word :
                        (rd_sel == CIFG_SEL_STATUS) ? status_word :
                        32'h0;

  // Flag registers; all state freezes while ce is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_reg <= GATE_RST;
      stack_reg <= STACK_RST;
      level_reg <= LEVEL_RST;
    end else if (ce) begin
      gate_reg <= gate_next;
      stack_reg <= stack_next;
      level_reg <= level_next;
    end
  end

  // Acceptance pulse toward the sequencer, one cycle per accepted request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_reg <= 1'b0;
      acc_level_reg <= 3'h0;
      acc_maskable_reg <= 1'b0;
    end else if (ce) begin
      accept_reg <= eligible;
      if (eligible) begin
        acc_level_reg <= irq_in.level;
        acc_maskable_reg <= irq_in.maskable;
      end
    end
  end

  // Write address and data are taken independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else if (ce) begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_hold_reg <= 1'b0;
      end else if (b_done) begin
        awready_reg <= 1'b1;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_do) begin
        w_hold_reg <= 1'b0;
      end else if (b_done) begin
        wready_reg <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_sel == CIFG_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (b_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel: data one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= (rd_sel == CIFG_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (r_done) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Every output comes straight from a flip-flop.
  assign irq_accept = accept_reg;
  assign accept_level = acc_level_reg;
  assign gate_flag = gate_reg;
  assign stack_sel = stack_reg;
  assign cpu_priority_level = level_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Checks on the flag behaviour, all in the single clock domain.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A closed gate refuses a maskable request.
  property p_gate_refuse;
    ce && irq_in.valid && irq_in.maskable && !gate_reg |=> !irq_accept;
  endproperty
  a_gate_refuse: assert property (p_gate_refuse)
    else $error("maskable request accepted with gate closed");

  // An open gate with a higher priority request is accepted.
  property p_gate_open;
    ce && irq_in.valid && irq_in.maskable && gate_reg && prio_ok &&
      !accept_reg |=> irq_accept ##1 !irq_accept;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("eligible maskable request not accepted");

  // Acceptance leaves the gate closed.
  property p_ack_clears_gate;
    irq_accept |-> !gate_flag;
  endproperty
  a_ack_clears_gate: assert property (p_ack_clears_gate)
    else $error("gate still open after acknowledge");

  // A software write sets the stack choice when nothing clears it.
  property p_stack_write;
    flag_wr && !accept_fire && !trap_low |=>
      stack_sel == $past(wdata_reg[STACK_BIT]);
  endproperty
  a_stack_write: assert property (p_stack_write)
    else $error("stack choice did not follow write");

  // Low trap numbers select the handler stack.
  property p_trap_low;
    trap_low |=> !stack_sel;
  endproperty
  a_trap_low: assert property (p_trap_low)
    else $error("trap 0 to 31 left task stack selected");

  // High trap numbers keep the stack choice.
  property p_trap_high;
    trap_fire && !trap_low && !accept_fire && !flag_wr |=>
      $stable(stack_sel);
  endproperty
  a_trap_high: assert property (p_trap_high)
    else $error("trap above 31 changed stack choice");

  // The level field takes the written three bits.
  property p_level_write;
    flag_wr |=> cpu_priority_level == $past(wdata_reg[6:4]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("priority level did not take written value");

  // Equal or lower priority is held off.
  property p_prio_strict;
    ce && irq_in.valid && irq_in.maskable &&
      irq_in.level <= level_reg |=> !irq_accept;
  endproperty
  a_prio_strict: assert property (p_prio_strict)
    else $error("request at or below level accepted");

  // Flag reads return zero in the reserved bit.
  property p_rsvd_read;
    ar_take && rd_sel == CIFG_SEL_FLAGS |=> !s_axi_rdata[RSVD_BIT];
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved bit read nonzero");

  // A maskable accept had both gate and priority one cycle earlier.
  // Every maskable accept is checked, whatever level it carried.
  property p_both_permit;
    irq_accept && acc_maskable_reg |->
      $past(gate_reg) && $past(prio_ok);
  endproperty
  a_both_permit: assert property (p_both_permit)
    else $error("maskable accept without both permissions");

  // Main scenarios worth seeing.
  c_accept: cover property (irq_accept && acc_maskable_reg);
  c_trap_low: cover property (trap_low && stack_reg);
  c_flag_write: cover property (flag_wr ##1 gate_flag);
  c_read_status: cover property (ar_take && rd_sel == CIFG_SEL_STATUS);

endmodule

/* design/cifg_pkg.sv */
// Shared constants and carrier types for the interrupt flag gating block.
// Summary of operation
// - Gate flag low refuses all maskable requests.
// - Acknowledging any interrupt clears the gate flag.
// - Stack choice 0 handler, 1 task pointer.
// - Hardware interrupt or trap 0-31 clears stack choice.
// - Priority level field is three bits, 0-7.
// - Request priority must strictly exceed current level; the code checks this for maskable requests only.
// - Reserved bit written 0, read value undefined.
package cifg_pkg;

  // Register byte offsets within the slave window.
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Field positions in the flag register.
  localparam int GATE_BIT = 0;
  localparam int STACK_BIT = 1;
  localparam int RSVD_BIT = 2;
  localparam int LEVEL_LSB = 4;
  localparam int LEVEL_W = 3;

  // Field positions in the status register.
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_MASKABLE_BIT = 3;
  localparam int ST_ELIGIBLE_BIT = 8;

  // Reset values of the flag fields.
  localparam logic GATE_RST = 1'b0;
  localparam logic STACK_RST = 1'b0;
  localparam logic [2:0] LEVEL_RST = 3'h0;

  // Highest trap number that also switches to the handler stack.
  localparam logic [5:0] TRAP_CLEAR_MAX = 6'h1f;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded register selection.
  typedef enum logic [1:0] {
    CIFG_SEL_NONE = 2'b00,
    CIFG_SEL_FLAGS = 2'b01,
    CIFG_SEL_STATUS = 2'b10
  } cifg_sel_t;

  // An interrupt request offered by the request logic.
  typedef struct packed {
    logic valid;
    logic maskable;
    logic [2:0] level;
  } cifg_irq_t;

  // A software trap being executed by the sequencer.
  typedef struct packed {
    logic exec;
    logic [5:0] num;
  } cifg_trap_t;

endpackage

/* bench/cifg_req_model.sv */
// Request logic and trap sequencer model facing the flag gating unit.
module cifg_req_model (
  input wire logic aclk,
  input wire logic irq_accept,
  output cifg_pkg::cifg_irq_t irq_out,
  output cifg_pkg::cifg_trap_t trap_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import cifg_pkg::*;

  // Nothing is requested before the bench asks for it.
  initial begin
    irq_out = '0;
    trap_out = '0;
  end

  // Holds a request until it is taken or four edges pass.
  task automatic offer(input logic m, input logic [2:0] lvl,
                       input int gap, output logic taken);
    taken = 1'b0;
    repeat (gap + 1) @(posedge aclk);
    irq_out <= '{1'b1, m, lvl};
    for (int i = 0; i < 4 && !taken; i++) begin
      @(posedge aclk);
      if (irq_accept === 1'b1) taken = 1'b1;
    end
    // A released request shows inverted fields, so stale data cannot pass.
    irq_out <= '{1'b0, ~m, ~lvl};
  endtask

  // One-cycle trap pulse, as the sequencer issues it.
  task automatic trap(input logic [5:0] n);
    @(posedge aclk);
    trap_out <= '{1'b1, n};
    @(posedge aclk);
    trap_out <= '{1'b0, ~n};
  endtask
endmodule

/* bench/cpu_interrupt_flag_gating_tb.sv */
// Self-checking bench for the interrupt flag gating unit.
module cpu_interrupt_flag_gating_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cifg_pkg::*;

  logic aclk, aresetn, ce;
  cifg_irq_t irq_in;
  cifg_trap_t trap_in;
  logic irq_accept, gate_flag, stack_sel;
  logic [2:0] accept_level, cpu_priority_level;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] rd;
  logic taken;
  int fails = 0;
  int comparisons = 0;

  cifg_gate #(.ADDR_W(8)) cifg_gate_inst (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .irq_in(irq_in), .trap_in(trap_in), .irq_accept(irq_accept),
    .accept_level(accept_level), .gate_flag(gate_flag),
    .stack_sel(stack_sel), .cpu_priority_level(cpu_priority_level),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  cifg_req_model cifg_req_model_inst (.aclk(aclk), .irq_accept(irq_accept),
    .irq_out(irq_in), .trap_out(trap_in));

  // Free-running 20 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask

  // A bus answer that never comes ends the run.
  task automatic timeout();
    fails++;
    $display("Error bus answer expected within 20 cycles seen none");
    stop_test();
  endtask

  // Lets the edge's updates land before outputs are judged.
  task automatic settle();
    @(negedge aclk);
  endtask

  // AXI write: address and data offered together, each released when taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timeout();
    settle();
  endtask

  // AXI read: data and response are taken at the rvalid edge.
  task automatic axi_read(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) timeout();
    settle();
  endtask

  // Flags come out of reset cleared.
  task automatic s_reset();
    axi_read(FLAGS_OFS);
    chk_word("flags after reset", 32'h0, rd);
    chk_bit("gate after reset", GATE_RST, gate_flag);
    chk_bit("stack after reset", STACK_RST, stack_sel);
  endtask

  // Field widths, stack choice both ways, and an unmapped read.
  task automatic s_fields();
    axi_write(FLAGS_OFS, 32'h0000_0073);
    chk_word("write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axi_read(FLAGS_OFS);
    chk_word("flags readback", 32'h0000_0073, rd);
    chk_word("level", 32'h7, {29'h0, cpu_priority_level});
    chk_bit("stack task", 1'b1, stack_sel);
    axi_write(FLAGS_OFS, 32'h0000_0001);
    chk_bit("stack handler", 1'b0, stack_sel);
    chk_word("level cleared", 32'h0, {29'h0, cpu_priority_level});
    // An unmapped write must leave the level field alone.
    axi_write(8'h08, 32'h0000_0070);
    chk_word("bad wr resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk_word("level kept", 32'h0, {29'h0, cpu_priority_level});
    axi_read(8'h08);
    chk_word("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk_word("unmapped data", 32'h0, rd);
  endtask

  // With the gate closed even the top level is refused.
  task automatic s_gate_off();
    axi_write(FLAGS_OFS, 32'h0000_0000);
    cifg_req_model_inst.offer(1'b1, 3'h7, 0, taken);
    settle();
    chk_bit("closed gate accept", 1'b0, taken);
  endtask

  // Equal level is held off, one above is taken and clears both flags.
  task automatic s_priority();
    axi_write(FLAGS_OFS, 32'h0000_0023);
    cifg_req_model_inst.offer(1'b1, 3'h2, 3, taken);
    settle();
    chk_bit("equal level accept", 1'b0, taken);
    chk_bit("gate kept", 1'b1, gate_flag);
    cifg_req_model_inst.offer(1'b1, 3'h3, 0, taken);
    settle();
    chk_bit("higher level accept", 1'b1, taken);
    chk_word("accept level", 32'h3, {29'h0, accept_level});
    chk_bit("gate after accept", 1'b0, gate_flag);
    chk_bit("stack after accept", 1'b0, stack_sel);
    axi_read(STATUS_OFS);
    chk_word("status", 32'h0000_000b, rd);
  endtask

  // A non-maskable request passes level 7 and still clears the flags.
  task automatic s_nonmask();
    axi_write(FLAGS_OFS, 32'h0000_0073);
    cifg_req_model_inst.offer(1'b0, 3'h0, 0, taken);
    settle();
    chk_bit("nonmask accept", 1'b1, taken);
    chk_bit("gate after nonmask", 1'b0, gate_flag);
    chk_bit("stack after nonmask", 1'b0, stack_sel);
  endtask

  // Trap 31 is the last number that returns to the handler stack.
  task automatic s_trap();
    axi_write(FLAGS_OFS, 32'h0000_0003);
    cifg_req_model_inst.trap(6'h1f);
    settle();
    chk_bit("stack after trap 31", 1'b0, stack_sel);
    chk_bit("gate after trap", 1'b0, gate_flag);
    axi_write(FLAGS_OFS, 32'h0000_0003);
    cifg_req_model_inst.trap(6'h20);
    settle();
    chk_bit("stack after trap 32", 1'b1, stack_sel);
  endtask

  // With the clock enable low nothing is accepted and the flags hold.
  task automatic s_freeze();
    axi_write(FLAGS_OFS, 32'h0000_0003);
    @(posedge aclk);
    ce <= 1'b0;
    cifg_req_model_inst.offer(1'b0, 3'h0, 0, taken);
    @(posedge aclk);
    ce <= 1'b1;
    settle();
    chk_bit("frozen accept", 1'b0, taken);
    chk_bit("frozen gate", 1'b1, gate_flag);
    chk_bit("frozen stack", 1'b1, stack_sel);
  endtask

  // Reset for ten cycles, then every scenario in turn.
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_fields();
    s_gate_off();
    s_priority();
    s_nonmask();
    s_trap();
    s_freeze();
    stop_test();
  end
endmodule
